// *** inc/hcr_pkg.sv ***
/*
 * Constants and types shared by the heater control register block.
 * Assumes a single 25 MHz clock; all serial bus pins are sampled on it.
 */
package hcr_pkg;

  // ************************************************************
  // Register layout
  // ************************************************************
  localparam logic [7:0] HCR_CTRL_RESET = 8'h00;
  localparam int HCR_EN_POS = 4;
  localparam int HCR_SEL_MSB = 3;
  localparam int HCR_SEL_LSB = 0;
  localparam int HCR_FIELD_W = 5;
  localparam logic [2:0] HCR_SPARE_READ = 3'h7;
  localparam logic [7:0] HCR_UNDEF_READ = 8'hff;

  // ************************************************************
  // Serial bus defaults
  // ************************************************************
  localparam logic [6:0] HCR_DEF_ADDR = 7'h50;
  localparam logic [7:0] HCR_DEF_WR_CMD = 8'h51;
  localparam logic [7:0] HCR_DEF_RD_CMD = 8'h52;
  localparam logic [3:0] HCR_BYTE_BITS = 4'h8;
  localparam logic [3:0] HCR_CNT_RESET = 4'h0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [3:0] {
    HCR_IDLE,
    HCR_ADDR,
    HCR_ADDR_ACK,
    HCR_CMD,
    HCR_CMD_ACK,
    HCR_WDATA,
    HCR_WDATA_ACK,
    HCR_RDATA,
    HCR_RACK
  } hcr_state_t;

  typedef enum logic [1:0] {
    HCR_CMD_NONE,
    HCR_CMD_RD,
    HCR_CMD_WR,
    HCR_CMD_OTHER
  } hcr_cmd_t;

endpackage

// *** hw/hcr_pin_sync.sv ***
/*
 * Two-flop synchroniser with edge detection for one serial bus pin.
 * Assumes the pin is asynchronous to clk; edges are found on the
 * second flop and a delayed copy only.
 */
`timescale 1ns/1ns
module hcr_pin_sync
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pin
  input wire logic pin_i,
  // Synchronised view
  output logic level,
  output logic rise,
  output logic fall
);
  import hcr_pkg::*;

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } hcr_sync_t;

  hcr_sync_t s_reg;
  hcr_sync_t s_next;

  always_comb
  begin
    s_next.meta = pin_i;
    s_next.sync = s_reg.meta;
    s_next.last = s_reg.sync;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_reg <= 3'h7;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign level = s_reg.sync;
  assign rise = s_reg.sync & ~s_reg.last;
  assign fall = ~s_reg.sync & s_reg.last;

endmodule

// *** hw/hcr_top.sv ***
/*
 * Serial bus slave holding the heater control register.
 * Assumes an external master on SCL/SDA with a pull-up on SDA; SCL is
 * sampled by clk, so the bus must run well below a quarter of clk.
 */
`timescale 1ns/1ns
// Summary of operation
// - Reads of unlisted locations return an arbitrary value, here all ones.
// - Reserved bits of the register read back as one.
// - Writes leave reserved bits unchanged whatever the host sends.
// - Register resets to zero: heater off, lowest drive code.
// - Bit 4 enables the heater when one, disables when zero.
// - Bits 3 to 0 select heater drive strength, larger is stronger.
// - Read: command, repeated start, one byte, no checksum; write: command, byte.
module hcr_top
#(
  parameter logic [6:0] DEV_ADDR = hcr_pkg::HCR_DEF_ADDR,
  parameter logic [7:0] WR_CMD = hcr_pkg::HCR_DEF_WR_CMD,
  parameter logic [7:0] RD_CMD = hcr_pkg::HCR_DEF_RD_CMD
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Heater drive
  output logic heater_enable_bit,
  output logic [hcr_pkg::HCR_SEL_MSB:0] heater_current_sel
);
  import hcr_pkg::*;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic scl_lvl;
  logic scl_rise;
  logic scl_fall;
  logic sda_lvl;
  logic sda_rise;
  logic sda_fall;

  hcr_pin_sync u_scl
  (
    .clk(clk),
    .srst(srst),
    .pin_i(scl_i),
    .level(scl_lvl),
    .rise(scl_rise),
    .fall(scl_fall)
  );

  hcr_pin_sync u_sda
  (
    .clk(clk),
    .srst(srst),
    .pin_i(sda_i),
    .level(sda_lvl),
    .rise(sda_rise),
    .fall(sda_fall)
  );

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    hcr_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic rw;
    logic mack;
    hcr_cmd_t cmd;
    logic sda_low;
    logic [HCR_FIELD_W-1:0] heater_control;
  } hcr_regs_t;

  hcr_regs_t r_reg;
  hcr_regs_t r_next;

  // Byte returned on a read, by last command
  function automatic logic [7:0] hcr_read_byte(input hcr_cmd_t c,
                                               input logic [HCR_FIELD_W-1:0] f);
    if (c == HCR_CMD_RD)
    begin
      hcr_read_byte = {HCR_SPARE_READ, f};
    end
    else
    begin
      hcr_read_byte = HCR_UNDEF_READ;
    end
  endfunction

  // Command byte decode
  function automatic hcr_cmd_t hcr_decode(input logic [7:0] b);
    if (b == RD_CMD)
    begin
      hcr_decode = HCR_CMD_RD;
    end
    else if (b == WR_CMD)
    begin
      hcr_decode = HCR_CMD_WR;
    end
    else
    begin
      hcr_decode = HCR_CMD_OTHER;
    end
  endfunction

  logic start_det;
  logic stop_det;
  logic [7:0] tx_byte;

  assign start_det = scl_lvl & sda_fall;
  assign stop_det = scl_lvl & sda_rise;
  assign tx_byte = hcr_read_byte(r_reg.cmd, r_reg.heater_control);

  // ************************************************************
  // Bus slave sequencer
  // ************************************************************
  always_comb
  begin
    r_next = r_reg;
    if (start_det)
    begin
      r_next.state = HCR_ADDR;
      r_next.bit_cnt = HCR_CNT_RESET;
      r_next.sda_low = 1'b0;
    end
    else if (stop_det)
    begin
      r_next.state = HCR_IDLE;
      r_next.sda_low = 1'b0;
    end
    else
    begin
      unique case (r_reg.state)
        HCR_IDLE:
        begin
          r_next.sda_low = 1'b0;
        end
        HCR_ADDR, HCR_CMD, HCR_WDATA:
        begin
          if (scl_rise)
          begin
            r_next.shreg = {r_reg.shreg[6:0], sda_lvl};
            r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
          end
          else if (scl_fall && r_reg.bit_cnt == HCR_BYTE_BITS)
          begin
            r_next.sda_low = 1'b1;
            if (r_reg.state == HCR_ADDR)
            begin
              if (r_reg.shreg[7:1] == DEV_ADDR)
              begin
                r_next.rw = r_reg.shreg[0];
                r_next.state = HCR_ADDR_ACK;
              end
              else
              begin
                r_next.sda_low = 1'b0;
                r_next.state = HCR_IDLE;
              end
            end
            else if (r_reg.state == HCR_CMD)
            begin
              r_next.cmd = hcr_decode(r_reg.shreg);
              r_next.state = HCR_CMD_ACK;
            end
            else
            begin
              if (r_reg.cmd == HCR_CMD_WR)
              begin
                // Spare bits are not stored, only the live fields
                r_next.heater_control = r_reg.shreg[HCR_FIELD_W-1:0];
              end
              r_next.state = HCR_WDATA_ACK;
            end
          end
        end
        HCR_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            r_next.bit_cnt = HCR_CNT_RESET;
            if (r_reg.rw)
            begin
              r_next.shreg = tx_byte;
              r_next.sda_low = ~tx_byte[7];
              r_next.state = HCR_RDATA;
            end
            else
            begin
              r_next.sda_low = 1'b0;
              r_next.state = HCR_CMD;
            end
          end
        end
        HCR_CMD_ACK:
        begin
          if (scl_fall)
          begin
            r_next.sda_low = 1'b0;
            r_next.bit_cnt = HCR_CNT_RESET;
            // Read command waits for the repeated start
            r_next.state = (r_reg.cmd == HCR_CMD_RD) ? HCR_IDLE : HCR_WDATA;
          end
        end
        HCR_WDATA_ACK:
        begin
          if (scl_fall)
          begin
            r_next.sda_low = 1'b0;
            r_next.state = HCR_IDLE;
          end
        end
        HCR_RDATA:
        begin
          if (scl_rise)
          begin
            r_next.bit_cnt = r_reg.bit_cnt + 4'h1;
          end
          else if (scl_fall)
          begin
            if (r_reg.bit_cnt == HCR_BYTE_BITS)
            begin
              r_next.sda_low = 1'b0;
              r_next.state = HCR_RACK;
            end
            else
            begin
              r_next.shreg = {r_reg.shreg[6:0], 1'b0};
              r_next.sda_low = ~r_reg.shreg[6];
            end
          end
        end
        HCR_RACK:
        begin
          if (scl_rise)
          begin
            r_next.mack = sda_lvl;
          end
          else if (scl_fall)
          begin
            r_next.bit_cnt = HCR_CNT_RESET;
            if (!r_reg.mack)
            begin
              // No checksum: an acked byte is simply sent again
              r_next.shreg = tx_byte;
              r_next.sda_low = ~tx_byte[7];
              r_next.state = HCR_RDATA;
            end
            else
            begin
              r_next.state = HCR_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      r_reg.state <= HCR_IDLE;
      r_reg.bit_cnt <= HCR_CNT_RESET;
      r_reg.shreg <= 8'h00;
      r_reg.rw <= 1'b0;
      r_reg.mack <= 1'b1;
      r_reg.cmd <= HCR_CMD_NONE;
      r_reg.sda_low <= 1'b0;
      r_reg.heater_control <= HCR_CTRL_RESET[HCR_FIELD_W-1:0];
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign sda_o = 1'b0;
  assign sda_oe = r_reg.sda_low;
  assign heater_enable_bit = r_reg.heater_control[HCR_EN_POS];
  assign heater_current_sel = r_reg.heater_control[HCR_SEL_MSB:HCR_SEL_LSB];

endmodule

// *** dv/hcr_chk.sv ***
/* Pin assertions for the heater control register block.
   Bound to hcr_top; every pin is sampled on clk. */
`timescale 1ns/1ns
module hcr_chk
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // Heater drive
  input wire logic heater_enable_bit,
  input wire logic [hcr_pkg::HCR_SEL_MSB:0] heater_current_sel
);
  import hcr_pkg::*;
  // ********
  // Properties
  // ********
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  logic [4:0] ht;
  assign ht = {heater_enable_bit, heater_current_sel};
  sequence s_quiet;
    (ht == 5'h00 && !sda_oe) [*8];
  endsequence
  property p_rst;
    $fell(srst) |-> s_quiet;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_ht_0;
    $fell(srst) |-> ht == 5'h00;
  endproperty
  a_ht_0: assert property (p_ht_0) else $error("heater reset");
  property p_sdo;
    sda_o == 1'b0;
  endproperty
  a_sdo: assert property (p_sdo) else $error("sda_o high");
  property p_oe_lo;
    $changed(sda_oe) |-> !scl_i && !$past(scl_i);
  endproperty
  a_oe_lo: assert property (p_oe_lo) else $error("sda moved early");
  property p_oe_hi;
    scl_i && $past(scl_i) |-> $stable(sda_oe);
  endproperty
  a_oe_hi: assert property (p_oe_hi) else $error("sda moved in high");
  property p_oe_std;
    $rose(sda_oe) |-> sda_oe [*4];
  endproperty
  a_oe_std: assert property (p_oe_std) else $error("sda drive short");
  property p_ht_lo;
    $changed(ht) |-> !scl_i && !$past(scl_i);
  endproperty
  a_ht_lo: assert property (p_ht_lo) else $error("heater moved early");
  property p_ht_ack;
    $changed(ht) |-> ##[0:2] sda_oe;
  endproperty
  a_ht_ack: assert property (p_ht_ack) else $error("heater without ack");
endmodule
bind hcr_top hcr_chk u_hcr_chk
(.clk(clk), .srst(srst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
 .heater_enable_bit(heater_enable_bit), .heater_current_sel(heater_current_sel));

// *** dv/hcr_host.sv ***
/* Serial bus master model for the heater control register block.
   Assumes a pull-up on sda; one bus bit is 8 clk. */
`timescale 1ns/1ns
module hcr_host
(
  // Clock
  input wire logic clk,
  // Bus
  input wire logic sda,
  output logic scl,
  output logic sda_m
);
  import hcr_pkg::*;
  // ********
  // Bus cycles
  // ********
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic tk(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    tk(2);
    sda_m = b;
    tk(2);
    scl = 1'b1;
    tk(4);
    r = sda;
    scl = 1'b0;
  endtask
  // Start when v is one, stop when zero
  task automatic cond(input logic v);
    tk(2);
    sda_m = v;
    tk(2);
    scl = 1'b1;
    tk(4);
    sda_m = ~v;
    tk(4);
    if (v)
      scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(1'b1, nak);
  endtask
  // Writes only ever use the heater register command
  task automatic access(input logic wr, input logic [7:0] c, input logic [7:0] d,
    output logic [7:0] q, output logic nak);
    logic [3:0] a;
    cond(1'b1);
    xfer({HCR_DEF_ADDR, 1'b0}, q, a[0]);
    xfer(wr ? HCR_DEF_WR_CMD : c, q, a[1]);
    if (wr)
      xfer(d, q, a[2]);
    else
    begin
      cond(1'b1);
      xfer({HCR_DEF_ADDR, 1'b1}, q, a[2]);
      xfer(8'hff, q, a[3]);
    end
    cond(1'b0);
    nak = |a[2:0];
  endtask
  // Read with the first byte acked, so the same byte comes twice
  task automatic read_twice(output logic [7:0] q0, output logic [7:0] q1,
    output logic nak);
    logic [2:0] a;
    logic m;
    cond(1'b1);
    xfer({HCR_DEF_ADDR, 1'b0}, q0, a[0]);
    xfer(HCR_DEF_RD_CMD, q0, a[1]);
    cond(1'b1);
    xfer({HCR_DEF_ADDR, 1'b1}, q0, a[2]);
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, q0[i]);
    bit_io(1'b0, m);
    xfer(8'hff, q1, m);
    cond(1'b0);
    nak = |a;
  endtask
  // Write frame to a foreign address: no acknowledge, no effect
  task automatic probe(input logic [6:0] adr, input logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic a;
    cond(1'b1);
    xfer({adr, 1'b0}, q, nak);
    xfer(HCR_DEF_WR_CMD, q, a);
    xfer(d, q, a);
    cond(1'b0);
  endtask
endmodule

// *** dv/hcr_top_tb.sv ***
/* Self-checking bench for the heater control register block.
   Drives hcr_top through the hcr_host bus model. */
`timescale 1ns/1ns
module hcr_top_tb;
  import hcr_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic scl;
  logic sda_m;
  logic sda;
  logic sda_oe;
  logic en;
  logic [3:0] sel;
  int n_errors = 0;
  int samples_checked = 0;
  always #20 clk = ~clk;
  // Open-drain wire with pull-up
  assign sda = sda_m & ~sda_oe;
  hcr_top u_hcr_top
  (.clk(clk), .srst(srst), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe),
   .heater_enable_bit(en), .heater_current_sel(sel));
  hcr_host u_hcr_host (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  // ********
  // Checking
  // ********
  function automatic logic [7:0] rd_exp(input logic [4:0] f);
    return {3'h7, f};
  endfunction
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #1000000;
    n_errors++;
    tally_and_finish();
  end
  // ********
  // Stimulus
  // ********
  initial
  begin
    logic [7:0] q;
    logic [7:0] d;
    logic nak;
    logic [4:0] f;
    f = 5'h00;
    void'($urandom(93));
    repeat (12) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 14; i++)
    begin
      if (i == 10)
      begin
        srst = 1'b1;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        f = 5'h00;
      end
      check("heat", {3'h0, en, sel}, {3'h0, f});
      u_hcr_host.access(1'b0, HCR_DEF_RD_CMD, 8'h00, q, nak);
      check("rd", q, rd_exp(f));
      check("rd_nak", {7'h00, nak}, 8'h00);
      d = (i == 0) ? 8'h1f : (i == 1) ? 8'he0 : 8'($urandom);
      if (i[0])
        d[7:5] = q[7:5];
      u_hcr_host.access(1'b1, 8'h00, d, q, nak);
      f = d[4:0];
      check("wr_nak", {7'h00, nak}, 8'h00);
    end
    check("heat", {3'h0, en, sel}, {3'h0, f});
    u_hcr_host.read_twice(q, d, nak);
    check("rd_first", q, rd_exp(f));
    check("rd_again", d, rd_exp(f));
    check("rd2_nak", {7'h00, nak}, 8'h00);
    u_hcr_host.probe(HCR_DEF_ADDR ^ 7'h01, ~{3'h0, f}, nak);
    check("other_addr_nak", {7'h00, nak}, 8'h01);
    check("heat_other_addr", {3'h0, en, sel}, {3'h0, f});
    u_hcr_host.access(1'b0, 8'h53, 8'h00, q, nak);
    check("unlisted", q, 8'hff);
    check("heat_kept", {3'h0, en, sel}, {3'h0, f});
    tally_and_finish();
  end
endmodule
